// ==== dv/prbs_tx_path_checker_tb.sv ====
`timescale 1ns/10ps
module prbs_tx_path_checker_tb;
	logic CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic go = 1'b0, inv = 1'b0, PREADY, PSLVERR, TXD_VALID, IRQ, busy;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic [7:0] TXD, cnt = 8'h00;
	int fail_count = 0, tests_run = 0, cyc = 0, n, exp_total;
	always #25 CLK = ~CLK;
	ptc_tx_checker u_ptc_tx_checker (.*);
	ptc_prbs_src u_ptc_prbs_src (.clk(CLK), .go(go), .inv(inv), .count(cnt), .valid(TXD_VALID),
		.data(TXD), .busy(busy));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// -----------
	// Bus and stream helpers
	// -----------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		rd = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic send(input int k, input logic i);
		cnt <= 8'(k);
		inv <= i;
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		@(posedge CLK);
		while (busy === 1'b1) @(posedge CLK);
		repeat (4) @(posedge CLK);
	endtask
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			end_sim;
		end
	end
	initial begin
		void'($urandom(7));
		repeat (10) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		apb(1'b0, 12'h0E4, 32'h0);
		chk("ctrl_rst", rd, 32'h0);
		apb(1'b0, 12'h0E8, 32'h0);
		chk("total_rst", rd, 32'h0);
		apb(1'b0, 12'h0EC, 32'h0);
		chk("unmapped", rd, 32'h0);
		apb(1'b1, 12'h104, 32'h7);
		apb(1'b1, 12'h0E4, 32'h2);
		apb(1'b0, 12'h0E4, 32'h0);
		chk("mode_rw", rd, 32'h2);
		send(5, 1'b0);
		apb(1'b1, 12'h0E4, 32'h1);
		n = $urandom_range(40, 20);
		exp_total = n;
		send(n, 1'b0);
		apb(1'b1, 12'h0E4, 32'h81);
		apb(1'b0, 12'h0E8, 32'h0);
		chk("total", rd, 32'(exp_total));
		apb(1'b0, 12'h0E4, 32'h0);
		chk("locked", rd, 32'h11);
		chk("irq_lock", {31'h0, IRQ}, 32'h1);
		send(3, 1'b0);
		exp_total += 3;
		apb(1'b0, 12'h0E8, 32'h0);
		chk("frozen", rd, 32'(n));
		apb(1'b1, 12'h100, 32'h7);
		chk("irq_clr", {31'h0, IRQ}, 32'h0);
		send(6, 1'b1);
		exp_total += 6;
		apb(1'b0, 12'h0E4, 32'h0);
		chk("lost", rd & 32'h31, 32'h21);
		chk("irq_lost", {31'h0, IRQ}, 32'h1);
		apb(1'b0, 12'h0E4, 32'h0);
		chk("lost_rd", rd & 32'h20, 32'h0);
		apb(1'b1, 12'h0E4, 32'h101);
		apb(1'b0, 12'h0E8, 32'h0);
		chk("snap_clr", rd, 32'(exp_total));
		apb(1'b0, 12'h0E4, 32'h0);
		chk("err_cnt", (rd >> 7) & 32'hFF, 32'h4);
		apb(1'b1, 12'h0E4, 32'h81);
		apb(1'b0, 12'h0E8, 32'h0);
		chk("cleared", rd, 32'h0);
		apb(1'b1, 12'h104, 32'h0);
		chk("irq_mask", {31'h0, IRQ}, 32'h0);
		end_sim;
	end
endmodule
bind ptc_tx_checker ptc_tx_checker_chk u_ptc_tx_checker_chk (.*);

// ==== dv/ptc_prbs_src.sv ====
`timescale 1ns/10ps
module ptc_prbs_src (
	input wire logic clk,
	input wire logic go,
	input wire logic inv,
	input wire logic [7:0] count,
	output logic valid,
	output logic [7:0] data,
	output logic busy
);
	logic [6:0] lfsr = 7'h7F;
	logic [7:0] b;
	initial {valid, data, busy} = 10'h000;
	// Idle data shows the inverse so a stale byte never looks fresh
	always @(posedge clk) begin
		if (go) begin
			busy <= 1'b1;
			repeat (count) begin
				for (int i = 0; i < 8; i++) begin
					b[i] = lfsr[6] ^ lfsr[5];
					lfsr = {lfsr[5:0], b[i]};
				end
				data <= inv ? ~b : b;
				valid <= 1'b1;
				repeat (2) @(posedge clk);
				valid <= 1'b0;
				data <= ~data;
				repeat (3) @(posedge clk);
			end
			busy <= 1'b0;
		end
	end
endmodule

// ==== dv/ptc_tx_checker_chk.sv ====
`timescale 1ns/10ps
// -------------------------
// Bus and interrupt checks
// -------------------------
module ptc_tx_checker_chk (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic TXD_VALID,
	input wire logic [7:0] TXD,
	input wire logic IRQ
);
	wire acc = PSEL && PENABLE;
	wire rda = acc && !PWRITE;
	wire [9:0] wa = PADDR[11:2];
	wire hit = wa == 10'h039 || wa == 10'h03A || wa == 10'h040 || wa == 10'h041;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	chk_ready_no_wait: assert property (acc |-> PREADY) else $error("wait");
	chk_err_in_access: assert property (PSLVERR |-> acc) else $error("stray");
	chk_unmapped_err: assert property (acc |-> PSLVERR == !hit) else $error("decode");
	chk_unmapped_zero: assert property (rda && !hit |-> PRDATA == 32'h0) else $error("unmap");
	chk_upper_zero: assert property (rda |-> PRDATA[31:16] == 16'h0) else $error("upper");
	chk_read_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA)) else $error("hold");
	chk_reset_quiet: assert property ($fell(SYS_RST) |-> PRDATA == 32'h0 && !IRQ) else $error("rst");
	chk_mask_quiet: assert property (acc && PWRITE && PADDR == 12'h104 && PWDATA[2:0] == 3'h0
		|=> !IRQ) else $error("irq");
	cover property (acc && PSLVERR);
	cover property ($rose(IRQ));
	cover property (acc && PWRITE && PWDATA[8]);
endmodule

// ==== logic/ptc_params.svh ====
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define PTC_IDX_CTRL 8'h39
`define PTC_IDX_TOTAL 8'h3A
`define PTC_IDX_IRQ_STS 8'h40
`define PTC_IDX_IRQ_MASK 8'h41

// Control register fields
`define PTC_BIT_EN 0
`define PTC_BIT_MODE 1
`define PTC_BIT_OVF 2
`define PTC_BIT_LOCKED 4
`define PTC_BIT_SYNC_LOST 5
`define PTC_BIT_SNAP 7
`define PTC_BIT_SNAP_CLR 8
`define PTC_ERR_LSB 7
`define PTC_ERR_MSB 14

// Reset values
`define PTC_CTRL_RST 16'h0000
`define PTC_TOTAL_RST 16'h0000

// Checker sync thresholds (bytes)
`define PTC_LOCK_GOOD 8'h08
`define PTC_LOSS_BAD 8'h04

// Interrupt status bits
`define PTC_IRQ_SYNC_LOST 0
`define PTC_IRQ_OVF 1
`define PTC_IRQ_LOCKED 2

`endif

// ==== logic/ptc_pkg.sv ====
package ptc_pkg;
	typedef enum logic [1:0] {PTC_HUNT, PTC_LOCKED} ptc_sync_e;
	typedef logic [7:0] ptc_byte_t;
endpackage

// ==== logic/ptc_seq_checker.sv ====
`timescale 1ns/10ps
`include "ptc_params.svh"
module ptc_seq_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	ptc_stream_if.checker_side s
);
	// ----------------------------------------
	// PRBS-7 byte prediction
	// ----------------------------------------
	function automatic logic [7:0] ptc_next_byte(input logic [7:0] b);
		logic [6:0] st;
		logic [7:0] o;
		// Newest bit sits in bit 7, so the shift state is the byte reversed
		st = {b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
		o = 8'h00;
		for (int i = 0; i < 8; i++) begin
			st = {st[5:0], st[6] ^ st[5]};
			o[i] = st[0];
		end
		return o;
	endfunction

	ptc_pkg::ptc_sync_e state_reg, state_next;
	logic [7:0] expect_reg;
	logic [7:0] good_reg;
	logic [7:0] bad_reg;
	wire logic mismatch = s.data != expect_reg;
	wire logic take = enable && s.valid;
	wire logic drop = state_reg == ptc_pkg::PTC_LOCKED && mismatch
		&& bad_reg == `PTC_LOSS_BAD - 8'h01;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ptc_pkg::PTC_HUNT: if (take && !mismatch && good_reg == `PTC_LOCK_GOOD - 8'h01)
				state_next = ptc_pkg::PTC_LOCKED;
			ptc_pkg::PTC_LOCKED: if (!enable || (take && drop))
				state_next = ptc_pkg::PTC_HUNT;
		endcase
	end

	// ----------------------------------------
	// Sync tracking
	// ----------------------------------------
	// Hunting self-seeds from the received byte, so any PRBS phase locks
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ptc_pkg::PTC_HUNT;
			expect_reg <= 8'h00;
			good_reg <= 8'h00;
			bad_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (take) begin
				expect_reg <= ptc_next_byte(state_reg == ptc_pkg::PTC_LOCKED ? expect_reg : s.data);
				good_reg <= mismatch ? 8'h00 : good_reg + 8'h01;
				bad_reg <= mismatch ? bad_reg + 8'h01 : 8'h00;
			end
			if (state_next != state_reg)
				good_reg <= 8'h00;
		end
	end

	assign s.locked = state_reg == ptc_pkg::PTC_LOCKED;
	assign s.err = take && s.locked && mismatch;
	assign s.lost = s.locked && take && drop;
endmodule

// ==== logic/ptc_stream_if.sv ====
`timescale 1ns/10ps
interface ptc_stream_if;
	logic valid;
	logic [7:0] data;
	logic err;
	logic locked;
	logic lost;
	modport checker_side (input valid, input data, output err, output locked, output lost);
	modport core_side (output valid, output data, input err, input locked, input lost);
endinterface

// ==== logic/ptc_tx_checker.sv ====
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "ptc_params.svh"
// What this block does
// - Checker runs only while control bit 0 enable is set.
// - Errored-byte count kept in read-only control bits 14 to 7.
// - Single mode: errored-byte counter stops at 0xFF.
// - Bit 1 selects continuous (1) or single (0) counting, single at reset.
// - Writing one to bit 7 snapshots counters for readback.
// - Writing one to bit 8 snapshots and clears counters.
// - Bit 5 latches high on sync loss until the control register is read.
// - Bit 4 shows live lock state.
// - Bit 2 sets when total-byte counter overflows.
// - Every checked byte counted in 16-bit total register.
// - Total register readback frozen on snapshot writes.
// - Single mode: total counter stops at 0xFFFF.
module ptc_tx_checker (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TXD_VALID,
	input wire logic [7:0] TXD,
	output logic IRQ
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic v1_reg, v2_reg, v3_reg, level_reg;
	logic [7:0] d1_reg, d2_reg, d3_reg;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			v1_reg <= 1'b0;
			v2_reg <= 1'b0;
			v3_reg <= 1'b0;
			level_reg <= 1'b0;
			d1_reg <= 8'h00;
			d2_reg <= 8'h00;
			d3_reg <= 8'h00;
		end else begin
			v1_reg <= TXD_VALID;
			v2_reg <= v1_reg;
			v3_reg <= v2_reg;
			if (v2_reg == v3_reg)
				level_reg <= v3_reg;
			d1_reg <= TXD;
			d2_reg <= d1_reg;
			d3_reg <= d2_reg;
		end
	end
	// Valid counts once the last two stages agree; a toggle per byte would allow
	// back-to-back bytes, but the loop rate is far below CLK here
	wire logic byte_valid = v2_reg && v3_reg && !level_reg;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire logic access = PSEL && PENABLE;
	wire logic [9:0] word = PADDR[11:2];
	wire logic hit_ctrl = word == 10'(`PTC_IDX_CTRL);
	wire logic hit_total = word == 10'(`PTC_IDX_TOTAL);
	wire logic hit_sts = word == 10'(`PTC_IDX_IRQ_STS);
	wire logic hit_mask = word == 10'(`PTC_IDX_IRQ_MASK);
	wire logic mapped = hit_ctrl || hit_total || hit_sts || hit_mask;
	wire logic wr = access && PWRITE && mapped;
	wire logic rd = access && !PWRITE && mapped;
	wire logic snap = wr && hit_ctrl && PWDATA[`PTC_BIT_SNAP];
	wire logic snap_clr = wr && hit_ctrl && PWDATA[`PTC_BIT_SNAP_CLR];
	wire logic ctrl_read = rd && hit_ctrl;

	// ----------------------------------------
	// Control and checker
	// ----------------------------------------
	logic enable_reg, mode_reg;
	wire logic [15:0] ctrl_rst = `PTC_CTRL_RST;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			enable_reg <= ctrl_rst[`PTC_BIT_EN];
			mode_reg <= ctrl_rst[`PTC_BIT_MODE];
		end else if (wr && hit_ctrl) begin
			enable_reg <= PWDATA[`PTC_BIT_EN];
			mode_reg <= PWDATA[`PTC_BIT_MODE];
		end
	end

	ptc_stream_if stream ();
	assign stream.valid = byte_valid;
	assign stream.data = d3_reg;
	ptc_seq_checker u_chk (
		.clk(CLK),
		.rst(SYS_RST),
		.enable(enable_reg),
		.s(stream.checker_side)
	);

	// ----------------------------------------
	// Counters and snapshots
	// ----------------------------------------
	logic [7:0] err_reg, err_snap_reg;
	logic [15:0] total_reg, total_snap_reg;
	logic ovf_reg, lost_reg;
	wire logic count = byte_valid && enable_reg;
	wire logic total_full = total_reg == 16'hFFFF;
	wire logic err_full = err_reg == 8'hFF;
	wire logic [15:0] total_next = (total_full && !mode_reg) ? total_reg
		: total_reg + 16'h0001;
	wire logic [7:0] err_next = (err_full && !mode_reg) ? err_reg : err_reg + 8'h01;
	always_ff @(posedge CLK) begin
		if (SYS_RST || snap_clr) begin
			total_reg <= `PTC_TOTAL_RST;
			err_reg <= 8'h00;
		end else begin
			if (count)
				total_reg <= total_next;
			if (stream.err)
				err_reg <= err_next;
		end
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			total_snap_reg <= `PTC_TOTAL_RST;
			err_snap_reg <= 8'h00;
		end else if (snap || snap_clr) begin
			total_snap_reg <= total_reg;
			err_snap_reg <= err_reg;
		end
	end
	// Overflow event wins over the clear in the same cycle
	wire logic ovf_evt = count && total_full;
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			ovf_reg <= 1'b0;
		else if (ovf_evt)
			ovf_reg <= 1'b1;
		else if (snap_clr)
			ovf_reg <= 1'b0;
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			lost_reg <= 1'b0;
		else if (stream.lost)
			lost_reg <= 1'b1;
		else if (ctrl_read)
			lost_reg <= 1'b0;
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [2:0] sts_reg, mask_reg;
	logic locked_d_reg;
	wire logic [2:0] evt = {stream.locked && !locked_d_reg, ovf_evt, stream.lost};
	wire logic [2:0] w1c = (wr && hit_sts) ? PWDATA[2:0] : 3'h0;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sts_reg <= 3'h0;
			mask_reg <= 3'h0;
			locked_d_reg <= 1'b0;
		end else begin
			sts_reg <= (sts_reg & ~w1c) | evt;
			locked_d_reg <= stream.locked;
			if (wr && hit_mask)
				mask_reg <= PWDATA[2:0];
		end
	end
	assign IRQ = |(sts_reg & mask_reg);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire logic [15:0] ctrl_view = {1'b0, err_snap_reg, 1'b0, lost_reg, stream.locked, 1'b0,
		ovf_reg, mode_reg, enable_reg};
	wire logic [31:0] rdata = hit_ctrl ? {16'h0000, ctrl_view}
		: hit_total ? {16'h0000, total_snap_reg}
		: hit_sts ? {29'h0, sts_reg}
		: hit_mask ? {29'h0, mask_reg} : 32'h0;
	always_ff @(posedge CLK) begin
		if (SYS_RST)
			PRDATA <= 32'h0;
		else if (PSEL && !PENABLE && !PWRITE)
			PRDATA <= rdata;
	end
	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;
endmodule
